// >>> verilog/cwl_pkg.sv
/*
 Constants, types and register map of the configuration word loader.
 Assumes a 32-bit AXI4-Lite register bus and byte addresses as printed.
*/
package cwl_pkg;
    localparam logic [31:0] CFG_WORD_THREE_ADDR = 32'h1fc02ff0;
    localparam logic [31:0] CFG_WORD_TWO_ADDR = 32'h1fc02ff4;
    localparam logic [31:0] CFG_WORD_ONE_ADDR = 32'h1fc02ff8;
    localparam logic [31:0] CFG_WORD_ZERO_ADDR = 32'h1fc02ffc;
    localparam logic [31:0] NV_CONTROL_ADDR = 32'h1fc03000;
    localparam logic [31:0] LOADER_STATUS_ADDR = 32'h1fc03004;
    localparam logic [31:0] CHECKSUM_ADDR = 32'h1fc03008;
    localparam logic [31:0] DEVICE_ID_ADDR = 32'h1fc0300c;

    localparam logic [31:0] PROGRAM_FLASH_BASE = 32'h1d000000;
    localparam logic [31:0] PROGRAM_FLASH_END = 32'h1d07ffff;
    localparam logic [31:0] BOOT_FLASH_BASE = 32'h1fc00000;
    localparam logic [31:0] BOOT_FLASH_END = 32'h1fc02fff;

    localparam int CFG_WORDS = 4;
    localparam logic [31:0] CFG_ERASED = 32'hffffffff;
    localparam logic [31:0] CFG_MASK_ZERO = 32'h110ff00b;
    localparam logic [31:0] CFG_MASK_ONE = 32'h009ff7a7;
    localparam logic [31:0] CFG_MASK_TWO = 32'h00070077;
    localparam logic [31:0] CFG_MASK_THREE = 32'h00000000;
    localparam logic [31:0] DEVICE_ID_MASK = 32'h000ff000;
    // Arbitrary identification value
    localparam logic [31:0] DEVICE_ID_VALUE = 32'h0a5c3001;

    localparam int CODE_PROTECT_BIT = 28;
    localparam int OSC_FIELD_LSB = 0;
    localparam logic [2:0] OSC_FAST_RC = 3'h0;
    localparam logic [1:0] MAX_PROGRAMS = 2'h2;

    localparam int CTRL_ERASE_BIT = 0;
    localparam int CTRL_START_BIT = 1;
    localparam int STAT_LOADED_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_DONE_BIT = 2;
    localparam int STAT_PROTECT_BIT = 3;
    localparam int STAT_OVERPROG_BIT = 4;
    localparam int STAT_FLASH_OK_BIT = 5;
    localparam int STAT_OSC_LSB = 8;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        CWL_MODE_RUN,
        CWL_MODE_TWO_WIRE,
        CWL_MODE_FOUR_WIRE
    } cwl_mode_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic last;
    } cwl_sum_beat_t;
endpackage

// >>> verilog/cwl_loader.sv
/*
 Configuration word store, reset loader, oscillator choice and checksum engine.
 Assumes a 32-bit AXI4-Lite master and a flash reader that streams words
 of program and boot flash on the sum port while a checksum runs.
 Nonvolatile words start erased at power-up and are never touched by reset.
*/
// Design decision made here: register access over AXI4-Lite.
// How it works
// R1 - On every reset, copy each stored config word into its register before code runs.
// R2 - Erased bits read one; programming only clears bits; erase sets them back.
// R3 - Programmer writes a word at most twice, or once, before page erase.
// R4 - In two-wire programming mode ignore config oscillator choice and use fast RC.
// R5 - In four-wire mode use configured oscillator; absent source blocks flash operations (code only clears flash_ops_ok; program and erase still run).
// R6 - Config words sit at the highest boot flash addresses.
// R7 - Programmer writes config words just before verify, code protection last.
// R8 - When code protected, config words read zero and checksum reads zero.
// R9 - Boot flash sum excludes its final sixteen bytes holding the config words.
// R10 - Total adds program, boot, masked config and masked device ID byte sums.
// R11 - Checksum is the total inverted then incremented by one.
// R12 - Each config word is ANDed with its own mask before its bytes are summed.
// R13 - Device ID is ANDed with its mask before its four bytes are summed.
// R14 - Reprogrammed words reach the registers only at the next reset.
// R15 - All additions wrap at thirty-two bits.
`timescale 1ns/10ps
module cwl_loader
    import cwl_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire cwl_mode_t prog_mode,
    input wire logic [7:0] osc_present,
    input wire cwl_sum_beat_t sum_beat,
    input wire logic sum_valid,
    output logic sum_ready,
    output logic core_run,
    output logic [2:0] osc_select,
    output logic flash_ops_ok
);
    typedef enum {LD_COPY, LD_RUN} cwl_ld_state_t;
    typedef enum {CS_IDLE, CS_SUM, CS_FINAL} cwl_cs_state_t;

    function automatic logic [31:0] byte_sum(input logic [31:0] w);
        byte_sum = {24'h000000, w[7:0]} + {24'h000000, w[15:8]}
            + {24'h000000, w[23:16]} + {24'h000000, w[31:24]};
    endfunction

    // Nonvolatile image; deliberately untouched by reset so new words survive it
    logic [31:0] nv_word [CFG_WORDS];
    logic [1:0] nv_programs [CFG_WORDS];
    logic [31:0] cfg_reg [CFG_WORDS];
    logic [31:0] cfg_mask [CFG_WORDS];
    logic [31:0] cfg_masked_sum [CFG_WORDS];

    initial begin
        for (int i = 0; i < CFG_WORDS; i++) begin
            nv_word[i] = CFG_ERASED;
            nv_programs[i] = 2'h0;
        end
    end

    cwl_ld_state_t ld_state;
    logic [1:0] ld_idx;
    cwl_cs_state_t cs_state;
    logic [31:0] program_flash_byte_sum;
    logic [31:0] boot_flash_byte_sum;
    logic [31:0] checksum;
    logic cs_done;
    logic overprogram;

    logic aw_held;
    logic w_held;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    assign cfg_mask[0] = CFG_MASK_ZERO;
    assign cfg_mask[1] = CFG_MASK_ONE;
    assign cfg_mask[2] = CFG_MASK_TWO;
    assign cfg_mask[3] = CFG_MASK_THREE;

    genvar g;
    generate
        for (g = 0; g < CFG_WORDS; g++) begin : g_cfg_sum
            assign cfg_masked_sum[g] = byte_sum(cfg_reg[g] & cfg_mask[g]); // R12
        end
    endgenerate

    wire code_protected = ~cfg_reg[0][CODE_PROTECT_BIT];
    wire [31:0] masked_config_byte_sum = cfg_masked_sum[0] + cfg_masked_sum[1]
        + cfg_masked_sum[2] + cfg_masked_sum[3]; // R15
    wire [31:0] device_id_byte_sum = byte_sum(DEVICE_ID_VALUE & DEVICE_ID_MASK); // R13
    wire [31:0] checksum_total = program_flash_byte_sum + boot_flash_byte_sum
        + masked_config_byte_sum + device_id_byte_sum; // R10 R15
    wire [31:0] next_checksum = code_protected ? 32'h00000000
        : ~checksum_total + 32'h00000001; // R11 R8

    // Reset loader: one word per cycle, core held until all four are in
    always_ff @(posedge clk) begin
        if (reset) begin
            ld_state <= LD_COPY;
            ld_idx <= 2'h0;
        end else if (ld_state == LD_COPY) begin
            ld_idx <= ld_idx + 2'h1;
            if (ld_idx == 2'h3) begin
                ld_state <= LD_RUN;
            end
        end
    end

    // Registers change only while loading, so new programs wait for a reset
    always_ff @(posedge clk) begin
        if (ld_state == LD_COPY) begin
            cfg_reg[ld_idx] <= nv_word[ld_idx]; // R1 R14
        end
    end

    assign core_run = (ld_state == LD_RUN); // R1

    // Follows the mode pin every cycle, so a mode change needs no reset
    wire [2:0] cfg_osc = cfg_reg[1][OSC_FIELD_LSB +: 3];
    wire [2:0] next_osc_select = (prog_mode == CWL_MODE_TWO_WIRE) ? OSC_FAST_RC : cfg_osc; // R4 R5
    wire next_flash_ops_ok = core_run && osc_present[next_osc_select]; // R5

    always_ff @(posedge clk) begin
        if (reset) begin
            osc_select <= OSC_FAST_RC;
            flash_ops_ok <= 1'b0;
        end else begin
            osc_select <= next_osc_select;
            flash_ops_ok <= next_flash_ops_ok;
        end
    end

    // Register decode
    wire [31:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
    wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
    wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
    wire aw_ok = aw_held || s_axi_awvalid;
    wire w_ok = w_held || s_axi_wvalid;
    wire wr_fire = aw_ok && w_ok && !s_axi_bvalid;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    // Config words occupy the top 16 bytes of boot flash
    wire wr_is_cfg = (wr_addr[31:4] == CFG_WORD_THREE_ADDR[31:4]); // R6
    wire wr_is_ctrl = (wr_addr == NV_CONTROL_ADDR);
    wire wr_hit = wr_is_cfg || wr_is_ctrl;
    wire [1:0] wr_word = 2'h3 - wr_addr[3:2];
    wire [31:0] strb_bits = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}},
        {8{wr_strb[0]}}};
    wire [31:0] program_value = wr_data | ~strb_bits;
    wire do_program = wr_fire && wr_is_cfg;
    wire do_erase = wr_fire && wr_is_ctrl && wr_strb[0] && wr_data[CTRL_ERASE_BIT];
    wire do_start = wr_fire && wr_is_ctrl && wr_strb[0] && wr_data[CTRL_START_BIT];

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;

    always_ff @(posedge clk) begin
        if (reset) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 32'h00000000;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else begin
            if (wr_fire) begin
                aw_held <= 1'b0;
            end else if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (wr_fire) begin
                w_held <= 1'b0;
            end else if (w_take) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Flash cells: programming can only pull bits low, erase restores ones
    // Plain always: the power-up erase above writes these cells as well
    always @(posedge clk) begin
        if (do_erase) begin
            for (int i = 0; i < CFG_WORDS; i++) begin
                nv_word[i] <= CFG_ERASED; // R2
                nv_programs[i] <= 2'h0;
            end
        end else if (do_program) begin
            nv_word[wr_word] <= nv_word[wr_word] & program_value; // R2
            if (nv_programs[wr_word] != 2'h3) begin
                nv_programs[wr_word] <= nv_programs[wr_word] + 2'h1;
            end
        end
    end

    // Flags a program beyond a word's allowance since the last erase; reset or erase clears the flag
    always_ff @(posedge clk) begin
        if (reset) begin
            overprogram <= 1'b0;
        end else if (do_program && nv_programs[wr_word] >= MAX_PROGRAMS) begin
            overprogram <= 1'b1; // R3
        end else if (do_erase) begin
            overprogram <= 1'b0;
        end
    end

    // Checksum engine
    wire beat_take = sum_valid && sum_ready;
    wire [31:0] beat_addr = sum_beat.addr;
    wire beat_last = sum_beat.last;
    wire in_program = (beat_addr >= PROGRAM_FLASH_BASE)
        && (beat_addr <= PROGRAM_FLASH_END);
    // Stop short of the config words; they are counted only through their masks
    wire in_boot = (beat_addr >= BOOT_FLASH_BASE)
        && (beat_addr < CFG_WORD_THREE_ADDR); // R9
    wire [31:0] beat_sum = byte_sum(sum_beat.data);
    wire cs_start = (cs_state == CS_IDLE) && do_start;
    wire add_program = beat_take && in_program;
    wire add_boot = beat_take && in_boot;
    wire cs_finish = (cs_state == CS_FINAL);

    assign sum_ready = (cs_state == CS_SUM);

    // Control path only; the sums and the result sit in their own registers
    always_ff @(posedge clk) begin
        if (reset) begin
            cs_state <= CS_IDLE;
        end else begin
            case (cs_state)
                CS_IDLE: begin
                    if (do_start) begin
                        cs_state <= CS_SUM;
                    end
                end
                CS_SUM: begin
                    if (beat_take && beat_last) begin
                        cs_state <= CS_FINAL;
                    end
                end
                CS_FINAL: begin
                    cs_state <= CS_IDLE;
                end
                default: begin
                    cs_state <= CS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset || cs_start) begin
            program_flash_byte_sum <= 32'h00000000;
        end else if (add_program) begin
            program_flash_byte_sum <= program_flash_byte_sum + beat_sum; // R15
        end
    end

    always_ff @(posedge clk) begin
        if (reset || cs_start) begin
            boot_flash_byte_sum <= 32'h00000000;
        end else if (add_boot) begin
            boot_flash_byte_sum <= boot_flash_byte_sum + beat_sum; // R9
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            checksum <= 32'h00000000;
            cs_done <= 1'b0;
        end else if (cs_start) begin
            cs_done <= 1'b0;
        end else if (cs_finish) begin
            checksum <= next_checksum; // R11
            cs_done <= 1'b1;
        end
    end

    // Read side
    wire rd_is_cfg = (s_axi_araddr[31:4] == CFG_WORD_THREE_ADDR[31:4]);
    wire [1:0] rd_word = 2'h3 - s_axi_araddr[3:2];
    wire cs_busy = (cs_state != CS_IDLE);
    wire [31:0] status_word = {20'h00000, 1'b0, osc_select, 2'h0,
        flash_ops_ok, overprogram, code_protected, cs_done,
        cs_busy, core_run};
    wire rd_is_ctrl = (s_axi_araddr == NV_CONTROL_ADDR);
    wire rd_is_stat = (s_axi_araddr == LOADER_STATUS_ADDR);
    wire rd_is_sum = (s_axi_araddr == CHECKSUM_ADDR);
    wire rd_is_id = (s_axi_araddr == DEVICE_ID_ADDR);
    wire rd_hit = rd_is_cfg || rd_is_ctrl || rd_is_stat || rd_is_sum || rd_is_id;
    // Protection hides every word, not only the one holding the protect bit
    wire [31:0] cfg_read = code_protected ? 32'h00000000 : cfg_reg[rd_word]; // R8
    wire [31:0] next_rdata = rd_is_cfg ? cfg_read :
        rd_is_stat ? status_word :
        rd_is_sum ? checksum :
        rd_is_id ? DEVICE_ID_VALUE : 32'h00000000;

    assign s_axi_arready = !s_axi_rvalid;
    wire rd_take = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// >>> tb/cwl_loader_sva.sv
/*
 Port checker for the configuration word loader.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module cwl_loader_sva
    import cwl_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire cwl_mode_t prog_mode,
    input wire logic [7:0] osc_present,
    input wire logic [2:0] osc_select,
    input wire logic core_run,
    input wire logic flash_ops_ok
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |=> s_axi_bvalid) else $error("write not answered next cycle");
    a_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_busy_refuses: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_load_then_run: assert property ($fell(reset) |-> !core_run ##[1:6] core_run)
        else $error("core released too early or too late");
    a_two_wire_rc: assert property (prog_mode == CWL_MODE_TWO_WIRE &&
        $past(prog_mode) == CWL_MODE_TWO_WIRE |-> osc_select == OSC_FAST_RC)
        else $error("two-wire mode not on fast rc");
    a_osc_gates_flash: assert property (core_run && $past(core_run) &&
        $stable(osc_present) && $stable(osc_select) |-> flash_ops_ok == osc_present[osc_select])
        else $error("flash ops flag disagrees with oscillator");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_run: cover property ($rose(core_run));
    c_two_wire: cover property (prog_mode == CWL_MODE_TWO_WIRE && core_run);
endmodule
bind cwl_loader cwl_loader_sva u_sva (.clk, .reset, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .prog_mode, .osc_present,
    .osc_select, .core_run, .flash_ops_ok);

// >>> tb/cwl_flash_model.sv
/*
 Flash reader model streaming a fixed word set for one checksum run.
 Assumes go pulses once per run; slow puts an idle cycle before each beat.
*/
`timescale 1ns/10ps
module cwl_flash_model
    import cwl_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic go,
    input wire logic slow,
    input wire logic sum_ready,
    output cwl_sum_beat_t sum_beat,
    output logic sum_valid
);
    logic [1:0] idx;
    logic active;
    logic gap;
    cwl_sum_beat_t cur;
    always_comb begin
        case (idx)
            2'h0: cur = '{32'h1d000000, 32'h11223344, 1'h0};
            2'h1: cur = '{32'h1fc00000, 32'hffffffff, 1'h0};
            2'h2: cur = '{CFG_WORD_THREE_ADDR, 32'hffffffff, 1'h0};
            default: cur = '{32'h1d07fffc, 32'h00000001, 1'h1};
        endcase
    end
    assign sum_valid = active && !gap;
    // Idle cycles carry inverted data so a stale word never looks valid
    assign sum_beat = sum_valid ? cur : cwl_sum_beat_t'(~cur);
    always_ff @(posedge clk) begin
        if (reset || go) begin
            active <= go;
            idx <= 2'h0;
            gap <= slow;
        end else if (sum_valid && sum_ready) begin
            idx <= idx + 2'h1;
            gap <= slow;
            active <= !cur.last;
        end else begin
            gap <= 1'h0;
        end
    end
endmodule

// >>> tb/cwl_loader_test.sv
/*
 Self-checking bench for the configuration word loader.
 Assumes the flash reader model on the sum port and a 4 ns clock.
*/
`timescale 1ns/10ps
module cwl_loader_test
    import cwl_pkg::*;
;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, go = 1'h0, slow = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic sum_valid, sum_ready, core_run, flash_ops_ok;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    cwl_mode_t prog_mode = CWL_MODE_RUN;
    logic [7:0] osc_present = 8'h02;
    logic [2:0] osc_select;
    cwl_sum_beat_t sum_beat;
    int miscompares = 0, checks = 0;
    // Holds off bready and rready until the answer is up
    logic late = 1'h0;
    always #2 clk = ~clk;
    cwl_loader u_dut (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .prog_mode, .osc_present, .sum_beat,
        .sum_valid, .sum_ready, .core_run, .osc_select, .flash_ops_ok);
    cwl_flash_model u_flash (.clk, .reset, .go, .slow, .sum_ready, .sum_beat, .sum_valid);
    task automatic complete_run;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic expire;
        miscompares++;
        complete_run();
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= !late;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid === 1'h1 && s_axi_bready === 1'h1) break;
            if (s_axi_bvalid === 1'h1) s_axi_bready <= 1'h1;
        end
        if (n == 50) expire();
        cmp({30'h0, s_axi_bresp}, {30'h0, er});
        s_axi_bready <= 1'h0;
    endtask
    task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= !late;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1) break;
            if (s_axi_rvalid === 1'h1) s_axi_rready <= 1'h1;
        end
        if (n == 50) expire();
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task automatic rd_cmp(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        cmp(d, e);
        cmp({30'h0, r}, {30'h0, er});
    endtask
    task automatic do_reset;
        int n;
        reset <= 1'h1;
        repeat (6) @(posedge clk);
        reset <= 1'h0;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (core_run === 1'h1) break;
        end
        if (n == 20) expire();
    endtask
    function automatic logic [31:0] bsum(input logic [31:0] v);
        return v[7:0] + v[15:8] + v[23:16] + v[31:24];
    endfunction
    // Streamed bytes are 0x4a7: the word at the top of boot flash is left out
    function automatic logic [31:0] expect_sum(input logic [31:0] w1);
        return ~(32'h4a7 + bsum(CFG_MASK_ZERO) + bsum(w1 & CFG_MASK_ONE) + bsum(CFG_MASK_TWO)
            + bsum(CFG_MASK_THREE) + bsum(DEVICE_ID_VALUE & DEVICE_ID_MASK)) + 32'h1;
    endfunction
    task automatic sum_check(input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        int n;
        axi_write(NV_CONTROL_ADDR, 32'h2, RESP_OKAY);
        go <= 1'h1;
        @(posedge clk);
        go <= 1'h0;
        for (n = 0; n < 100; n++) begin
            axi_read(LOADER_STATUS_ADDR, d, r);
            if (d[STAT_DONE_BIT] === 1'h1) break;
        end
        if (n == 100) expire();
        rd_cmp(CHECKSUM_ADDR, e, RESP_OKAY);
    endtask
    task automatic t_erased;
        for (int i = 0; i < 4; i++) begin
            rd_cmp(CFG_WORD_THREE_ADDR + 32'(4 * i), CFG_ERASED, RESP_OKAY);
        end
        rd_cmp(DEVICE_ID_ADDR, DEVICE_ID_VALUE, RESP_OKAY);
        rd_cmp(NV_CONTROL_ADDR, 32'h0, RESP_OKAY);
        // Late ready: the slave must hold its answer until it is accepted
        late = 1'h1;
        rd_cmp(32'h1fc03010, 32'h0, RESP_SLVERR);
        axi_write(32'h1fc03010, 32'h0, RESP_SLVERR);
        late = 1'h0;
    endtask
    task automatic t_program;
        logic [31:0] d;
        logic [1:0] r;
        axi_write(CFG_WORD_ONE_ADDR, 32'hfffffff9, RESP_OKAY);
        axi_write(CFG_WORD_ONE_ADDR, 32'hffff00ff, RESP_OKAY);
        axi_read(LOADER_STATUS_ADDR, d, r);
        cmp({31'h0, d[STAT_OVERPROG_BIT]}, 32'h0);
        // A third program of one word breaks the allowance and must be flagged
        axi_write(CFG_WORD_ONE_ADDR, 32'hffff00f9, RESP_OKAY);
        axi_read(LOADER_STATUS_ADDR, d, r);
        cmp({31'h0, d[STAT_OVERPROG_BIT]}, 32'h1);
        s_axi_wstrb <= 4'h1;
        axi_write(CFG_WORD_THREE_ADDR, 32'h0, RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rd_cmp(CFG_WORD_ONE_ADDR, CFG_ERASED, RESP_OKAY);
        prog_mode <= CWL_MODE_FOUR_WIRE;
        do_reset();
        rd_cmp(CFG_WORD_ONE_ADDR, 32'hffff00f9, RESP_OKAY);
        rd_cmp(CFG_WORD_THREE_ADDR, 32'hffffff00, RESP_OKAY);
        repeat (3) @(posedge clk);
        cmp({29'h0, osc_select}, 32'h1);
        cmp({31'h0, flash_ops_ok}, 32'h1);
        osc_present <= 8'h01;
        repeat (3) @(posedge clk);
        cmp({31'h0, flash_ops_ok}, 32'h0);
        prog_mode <= CWL_MODE_TWO_WIRE;
        repeat (3) @(posedge clk);
        cmp({29'h0, osc_select}, 32'h0);
        cmp({31'h0, flash_ops_ok}, 32'h1);
        prog_mode <= CWL_MODE_RUN;
        osc_present <= 8'h02;
    endtask
    task automatic t_checksum;
        sum_check(expect_sum(32'hffff00f9));
        slow <= 1'h1;
        sum_check(expect_sum(32'hffff00f9));
        slow <= 1'h0;
    endtask
    task automatic t_protect;
        // Protection is programmed last, after everything else is in place
        axi_write(CFG_WORD_ZERO_ADDR, 32'hefffffff, RESP_OKAY);
        do_reset();
        rd_cmp(CFG_WORD_ZERO_ADDR, 32'h0, RESP_OKAY);
        rd_cmp(CFG_WORD_ONE_ADDR, 32'h0, RESP_OKAY);
        sum_check(32'h0);
        axi_write(NV_CONTROL_ADDR, 32'h1, RESP_OKAY);
        do_reset();
        rd_cmp(CFG_WORD_ZERO_ADDR, CFG_ERASED, RESP_OKAY);
    endtask
    initial begin
        do_reset();
        t_erased();
        t_program();
        t_checksum();
        t_protect();
        complete_run();
    end
endmodule
